/* File: hw/vpa_pkg.sv */
// Purpose: constants, types and address map of the virtual port alias block
// Assumes: APB slave, 32-bit data, one aligned word per register index
// Notes:   byte address of a register is four times its index
//
// Functional notes
// [RQ1] alias pin-direction access acts exactly as the mapped port's direction register
// [RQ2] alias drive-value access acts exactly as the mapped port's output value register
// [RQ3] alias input read returns mapped port pin levels where input buffer enabled
// [RQ4] flag n sets when a pin sourcing interrupt n matches its input sense
// [RQ5] writing one to a flag clears it; writing zero leaves it unchanged
// [RQ6] alias flag access is identical to the mapped port's own flag register
// [RQ7] mapping control selects which port's registers appear in each alias window
// [RQ8] software writes zero to flag bits 7:2; they read back as zero
// [RQ9] four-bit map code per window; consecutive codes select consecutive ports
// [RQ10] alias window stores nothing; accesses forward combinationally to the port
package vpa_pkg;
    localparam int NPORT = 16;
    localparam int PW    = 8;
    localparam int MAPW  = 4;
    localparam int NWIN  = 4;
    localparam int NFLAG = 2;
    localparam int AW    = 12;
    localparam int DW    = 32;
    localparam int IDXW  = 10;
    localparam int OFFW  = 3;

    // register offsets inside one port block (alias windows reach the first four)
    localparam logic [OFFW-1:0] OFF_DIR   = 3'h0;
    localparam logic [OFFW-1:0] OFF_OUT   = 3'h1;
    localparam logic [OFFW-1:0] OFF_IN    = 3'h2;
    localparam logic [OFFW-1:0] OFF_FLAGS = 3'h3;
    localparam logic [OFFW-1:0] OFF_SENSE = 3'h4;
    localparam logic [OFFW-1:0] OFF_SRC0  = 3'h5;
    localparam logic [OFFW-1:0] OFF_SRC1  = 3'h6;
    localparam logic [OFFW-1:0] OFF_IEN   = 3'h7;

    // register indices
    localparam logic [IDXW-1:0] IDX_MAP_A   = 10'h010;
    localparam logic [IDXW-1:0] IDX_MAP_B   = 10'h011;
    localparam logic [IDXW-1:0] IDX_IRQ_ST  = 10'h012;
    localparam logic [IDXW-1:0] IDX_IRQ_MSK = 10'h013;
    localparam logic [5:0]      WIN_REGION  = 6'h00;
    localparam logic [2:0]      PORT_REGION = 3'h1;
    localparam int              MAP_HI_LSB  = 4;

    // reset values
    localparam logic [PW-1:0]    RST_DIR   = 8'h00;
    localparam logic [PW-1:0]    RST_OUT   = 8'h00;
    localparam logic [PW-1:0]    RST_SRC   = 8'h00;
    localparam logic [PW-1:0]    RST_IEN   = 8'hff;
    localparam logic [PW-1:0]    RST_MAP   = 8'h00;
    localparam logic [NFLAG-1:0] RST_FLAGS = 2'h0;

    typedef enum logic [1:0] {
        SENSE_BOTH = 2'b00,
        SENSE_RISE = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_LOW  = 2'b11
    } vpa_sense_e;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_PORT = 3'b001,
        K_MAPA = 3'b010,
        K_MAPB = 3'b011,
        K_IST  = 3'b100,
        K_IMSK = 3'b101
    } vpa_kind_e;

    typedef struct packed {
        logic            en;
        logic [OFFW-1:0] off;
        logic [PW-1:0]   data;
    } vpa_wr_s;

    typedef struct packed {
        logic [PW-1:0]    dir;
        logic [PW-1:0]    out;
        logic [PW-1:0]    in;
        logic [NFLAG-1:0] flags;
        vpa_sense_e       sense;
        logic [PW-1:0]    src0;
        logic [PW-1:0]    src1;
        logic [PW-1:0]    ien;
    } vpa_rd_s;

    typedef struct packed {
        vpa_kind_e       kind;
        logic [MAPW-1:0] port;
        logic [OFFW-1:0] off;
    } vpa_dec_s;

    typedef logic [NPORT-1:0][PW-1:0] vpa_pins_t;
endpackage

/* File: hw/vpa_sync.sv */
// Purpose: two-stage synchroniser for all port pin inputs
// Assumes: pins are asynchronous to clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module vpa_sync (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // pins
    input  wire vpa_pkg::vpa_pins_t d,
    output vpa_pkg::vpa_pins_t      q
);
    import vpa_pkg::*;

    typedef struct packed {
        vpa_pins_t s1;
        vpa_pins_t s2;
    } vpa_sync_s;

    vpa_sync_s s_q;
    vpa_sync_s s_d;

    always_comb begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule

/* File: hw/vpa_port.sv */
// Purpose: one physical port: direction, drive, input, sense and interrupt flags
// Assumes: pin levels arrive already synchronised
// Notes:   flag set wins over a same-cycle clear
`timescale 1ns/1ps
module vpa_port (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // register access
    input  wire vpa_pkg::vpa_wr_s wr,
    output vpa_pkg::vpa_rd_s      rd,
    // pins and events
    input  wire logic [7:0]       pin_sync,
    output logic                  flag_event
);
    import vpa_pkg::*;

    typedef struct packed {
        logic [PW-1:0]    dir;
        logic [PW-1:0]    out;
        logic [NFLAG-1:0] flags;
        vpa_sense_e       sense;
        logic [PW-1:0]    src0;
        logic [PW-1:0]    src1;
        logic [PW-1:0]    ien;
        logic [PW-1:0]    prev_in;
    } vpa_port_s;

    vpa_port_s        s_q;
    vpa_port_s        s_d;
    logic [PW-1:0]    in_now;
    logic [PW-1:0]    hit;
    logic [NFLAG-1:0] set;
    logic [NFLAG-1:0] clr;

    always_comb begin
        in_now = pin_sync & s_q.ien;
        unique case (s_q.sense)
            SENSE_BOTH: hit = in_now ^ s_q.prev_in;
            SENSE_RISE: hit = in_now & ~s_q.prev_in;
            SENSE_FALL: hit = ~in_now & s_q.prev_in;
            SENSE_LOW:  hit = ~in_now;
        endcase
        set  = {|(hit & s_q.src1), |(hit & s_q.src0)}; // RQ4
        clr  = '0;
        s_d  = s_q;
        s_d.prev_in = in_now;
        if (wr.en) begin
            unique case (wr.off)
                OFF_DIR:   s_d.dir = wr.data;
                OFF_OUT:   s_d.out = wr.data;
                OFF_IN:    ;
                OFF_FLAGS: clr = wr.data[NFLAG-1:0]; // RQ5
                OFF_SENSE: s_d.sense = vpa_sense_e'(wr.data[1:0]);
                OFF_SRC0:  s_d.src0 = wr.data;
                OFF_SRC1:  s_d.src1 = wr.data;
                OFF_IEN:   s_d.ien = wr.data;
            endcase
        end
        s_d.flags = (s_q.flags & ~clr) | set; // RQ5
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{dir: RST_DIR, out: RST_OUT, flags: RST_FLAGS, sense: SENSE_BOTH,
                     src0: RST_SRC, src1: RST_SRC, ien: RST_IEN, prev_in: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rd = '{dir: s_q.dir, out: s_q.out, in: in_now, flags: s_q.flags, // RQ3
                  sense: s_q.sense, src0: s_q.src0, src1: s_q.src1, ien: s_q.ien};
    assign flag_event = |set;
endmodule

/* File: hw/vpa_top.sv */
// Purpose: APB slave exposing four alias windows onto sixteen physical ports
// Assumes: zero-wait APB, pins asynchronous to clk
// Notes:   read data is captured in the setup cycle; status clears at the access edge
`timescale 1ns/1ps
module vpa_top (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [vpa_pkg::AW-1:0]        paddr,
    input  wire logic [vpa_pkg::DW-1:0]        pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic [vpa_pkg::DW-1:0]             prdata,
    output logic                               pready,
    output logic                               pslverr,
    // port pins
    input  wire vpa_pkg::vpa_pins_t            pin_in,
    output vpa_pkg::vpa_pins_t                 pin_out,
    output vpa_pkg::vpa_pins_t                 pin_oe,
    // interrupt
    output logic                               irq
);
    import vpa_pkg::*;

    typedef struct packed {
        logic [PW-1:0]    map_a;
        logic [PW-1:0]    map_b;
        logic [NPORT-1:0] irq_st;
        logic [NPORT-1:0] irq_msk;
        logic [NPORT-1:0] rd_clr;
        logic [DW-1:0]    prdata;
    } vpa_top_s;

    vpa_top_s         s_q;
    vpa_top_s         s_d;
    vpa_pins_t        pin_sync;
    vpa_wr_s          wr   [NPORT];
    vpa_rd_s          rd   [NPORT];
    logic [NPORT-1:0] ev;
    vpa_dec_s         dec;
    logic [PW-1:0]    rd_val;
    logic             acc;
    logic             wr_go;

    // map code of an alias window
    function automatic logic [MAPW-1:0] map_code(input logic [PW-1:0] ma, input logic [PW-1:0] mb,
                                                 input logic [1:0] win);
        logic [PW-1:0] r;
        r = win[1] ? mb : ma;
        map_code = win[0] ? r[MAP_HI_LSB +: MAPW] : r[0 +: MAPW]; // RQ9
    endfunction

    // address decode; alias windows resolve through the map code
    function automatic vpa_dec_s decode(input logic [AW-1:0] a, input logic [PW-1:0] ma,
                                        input logic [PW-1:0] mb);
        logic [IDXW-1:0] idx;
        idx    = a[AW-1:2];
        decode = '{kind: K_NONE, port: '0, off: '0};
        if (idx[IDXW-1:4] == WIN_REGION) begin
            decode.kind = K_PORT;
            decode.port = map_code(ma, mb, idx[3:2]); // RQ7
            decode.off  = {1'b0, idx[1:0]};
        end else if (idx[IDXW-1:7] == PORT_REGION) begin
            decode.kind = K_PORT;
            decode.port = idx[6:3];
            decode.off  = idx[2:0];
        end else if (idx == IDX_MAP_A) begin
            decode.kind = K_MAPA;
        end else if (idx == IDX_MAP_B) begin
            decode.kind = K_MAPB;
        end else if (idx == IDX_IRQ_ST) begin
            decode.kind = K_IST;
        end else if (idx == IDX_IRQ_MSK) begin
            decode.kind = K_IMSK;
        end
    endfunction

    vpa_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pin_in),
        .q     (pin_sync)
    );

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        vpa_port u_port (
            .clk        (clk),
            .rst_n      (rst_n),
            .wr         (wr[p]),
            .rd         (rd[p]),
            .pin_sync   (pin_sync[p]),
            .flag_event (ev[p])
        );
        assign pin_out[p] = rd[p].out;
        assign pin_oe[p]  = rd[p].dir;
    end

    always_comb begin
        dec   = decode(paddr, s_q.map_a, s_q.map_b);
        acc   = psel & penable;
        wr_go = acc & pwrite & pstrb[0];
        // forward writes with no local copy
        for (int p = 0; p < NPORT; p++) begin
            wr[p].en   = wr_go && dec.kind == K_PORT && dec.port == MAPW'(p); // RQ10 RQ6
            wr[p].off  = dec.off;
            wr[p].data = pwdata[PW-1:0];
        end
        rd_val = '0;
        if (dec.kind == K_PORT) begin
            unique case (dec.off)
                OFF_DIR:   rd_val = rd[dec.port].dir; // RQ1
                OFF_OUT:   rd_val = rd[dec.port].out; // RQ2
                OFF_IN:    rd_val = rd[dec.port].in; // RQ3
                OFF_FLAGS: rd_val = {{(PW-NFLAG){1'b0}}, rd[dec.port].flags}; // RQ6 RQ8
                OFF_SENSE: rd_val = {{(PW-2){1'b0}}, rd[dec.port].sense};
                OFF_SRC0:  rd_val = rd[dec.port].src0;
                OFF_SRC1:  rd_val = rd[dec.port].src1;
                OFF_IEN:   rd_val = rd[dec.port].ien;
            endcase
        end else if (dec.kind == K_MAPA) begin
            rd_val = s_q.map_a;
        end else if (dec.kind == K_MAPB) begin
            rd_val = s_q.map_b;
        end
        s_d = s_q;
        if (psel && !penable && !pwrite) begin
            s_d.rd_clr = '0;
            if (dec.kind == K_IST) begin
                s_d.prdata = {{(DW-NPORT){1'b0}}, s_q.irq_st};
                s_d.rd_clr = s_q.irq_st;
            end else if (dec.kind == K_IMSK) begin
                s_d.prdata = {{(DW-NPORT){1'b0}}, s_q.irq_msk};
            end else begin
                s_d.prdata = {{(DW-PW){1'b0}}, rd_val};
            end
        end
        if (wr_go && dec.kind == K_MAPA) begin
            s_d.map_a = pwdata[PW-1:0];
        end
        if (wr_go && dec.kind == K_MAPB) begin
            s_d.map_b = pwdata[PW-1:0];
        end
        if (wr_go && dec.kind == K_IMSK) begin
            s_d.irq_msk = pwdata[NPORT-1:0];
        end
        // read clears only what was returned; new events win
        if (acc && !pwrite && dec.kind == K_IST) begin
            s_d.irq_st = (s_q.irq_st & ~s_q.rd_clr) | ev;
        end else begin
            s_d.irq_st = s_q.irq_st | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{map_a: RST_MAP, map_b: RST_MAP, irq_st: '0, irq_msk: '0, rd_clr: '0, prdata: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pready  = acc;
    assign pslverr = acc && dec.kind == K_NONE;
    assign irq     = |(s_q.irq_st & s_q.irq_msk);
endmodule

/* File: tb/vpa_top_props.sv */
// Purpose: port-level assertions for the alias block
// Assumes: zero-wait apb slave
// Notes:   sees top ports only
`timescale 1ns/1ps
module vpa_top_props (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst_n,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [vpa_pkg::AW-1:0] paddr,
    input wire logic [vpa_pkg::DW-1:0] pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [vpa_pkg::DW-1:0] prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // pins and interrupt
    input wire vpa_pkg::vpa_pins_t     pin_in,
    input wire vpa_pkg::vpa_pins_t     pin_out,
    input wire vpa_pkg::vpa_pins_t     pin_oe,
    input wire logic                   irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable;
    wire wr0 = acc && pwrite && pstrb[0];

    a_ready_zero_wait: assert property (pready == acc) else $error("pready not zero wait");
    a_err_in_access: assert property (pslverr |-> acc) else $error("pslverr outside access");
    a_dir_hold: assert property (!wr0 |=> $stable(pin_oe)) else $error("direction moved");
    a_out_hold: assert property (!wr0 |=> $stable(pin_out)) else $error("drive moved");
    a_strobe_off: assert property (acc && pwrite && !pstrb[0] |=> $stable(pin_oe) && $stable(pin_out))
        else $error("masked write took effect");
    a_dir_direct: assert property (wr0 && paddr[11:9] == 3'h1 && paddr[4:2] == 3'h0
        |=> pin_oe[$past(paddr[8:5])] == $past(pwdata[7:0])) else $error("direction write lost");
    a_out_direct: assert property (wr0 && paddr[11:9] == 3'h1 && paddr[4:2] == 3'h1
        |=> pin_out[$past(paddr[8:5])] == $past(pwdata[7:0])) else $error("drive write lost");
    a_flag_upper: assert property (acc && !pwrite && paddr[11:6] == 6'h0 && paddr[3:2] == 2'h3
        |-> prdata[31:2] == 30'h0) else $error("flag upper bits set");
    cover property (wr0);
    cover property (irq);
    cover property (pslverr);
endmodule

/* File: tb/vpa_pin_model.sv */
// Purpose: outside world on the port pins
// Assumes: driven pins read back their drive
// Notes:   undriven pins follow ext
`timescale 1ns/1ps
module vpa_pin_model (
    // device side
    input  wire vpa_pkg::vpa_pins_t pin_out,
    input  wire vpa_pkg::vpa_pins_t pin_oe,
    // stimulus and pins
    input  wire vpa_pkg::vpa_pins_t ext,
    output vpa_pkg::vpa_pins_t      pin_in
);
    assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule

/* File: tb/virtual_port_alias_bench.sv */
// Purpose: self-checking bench for the alias block
// Assumes: zero-wait apb, pins through pin model
// Notes:   table rows, then input, flag and refusal cases
`timescale 1ns/1ps
module virtual_port_alias_bench;
    import vpa_pkg::*;
    typedef struct packed {
        logic [11:0] a;
        logic        w;
        logic [31:0] d;
    } vpa_row_s;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        err;
    logic [31:0] rd;
    vpa_pins_t   pin_in;
    vpa_pins_t   pin_out;
    vpa_pins_t   pin_oe;
    vpa_pins_t   ext = '0;
    int          failures = 0;
    int          n_checks = 0;
    vpa_row_s    rows [22] = '{
        '{12'h000, 1'b0, 32'h00},
        '{12'h004, 1'b0, 32'h00},
        '{12'h00c, 1'b0, 32'h00},
        '{12'h040, 1'b0, 32'h00},
        '{12'h000, 1'b1, 32'ha5},
        '{12'h200, 1'b0, 32'ha5},
        '{12'h004, 1'b1, 32'h3c},
        '{12'h204, 1'b0, 32'h3c},
        '{12'h040, 1'b1, 32'h21},
        '{12'h000, 1'b1, 32'h5a},
        '{12'h220, 1'b0, 32'h5a},
        '{12'h010, 1'b0, 32'h00},
        '{12'h014, 1'b1, 32'h99},
        '{12'h244, 1'b0, 32'h99},
        '{12'h044, 1'b1, 32'hf0},
        '{12'h030, 1'b1, 32'h77},
        '{12'h3e0, 1'b0, 32'h77},
        '{12'h020, 1'b0, 32'ha5},
        '{12'h204, 1'b1, 32'h6b},
        '{12'h024, 1'b0, 32'h6b},
        '{12'h3e0, 1'b1, 32'h18},
        '{12'h030, 1'b0, 32'h18}
    };

    always #25 clk = ~clk;

    vpa_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    vpa_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({31'h0, |{pin_out, pin_oe, irq}}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].d);
            else rdc(rows[i].a, rows[i].d);
        end
        chk({24'h0, pin_oe[1]}, 32'h5a);
        chk({24'h0, pin_out[2]}, 32'h99);
        $display("table test done");
        ext[2] <= 8'hc3;
        repeat (4) @(posedge clk);
        rdc(12'h018, 32'hc3);
        apb(12'h018, 1'b1, 32'hff);
        rdc(12'h248, 32'hc3);
        apb(12'h25c, 1'b1, 32'h0f);
        rdc(12'h018, 32'h03);
        $display("input test done");
        apb(12'h254, 1'b1, 32'h01);
        apb(12'h258, 1'b1, 32'h02);
        apb(12'h250, 1'b1, 32'h01);
        apb(12'h04c, 1'b1, 32'h04);
        ext[2] <= 8'h00;
        repeat (5) @(posedge clk);
        ext[2] <= 8'h03;
        repeat (5) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rdc(12'h01c, 32'h3);
        rdc(12'h24c, 32'h3);
        apb(12'h01c, 1'b1, 32'h1);
        rdc(12'h24c, 32'h2);
        apb(12'h24c, 1'b1, 32'h0);
        rdc(12'h01c, 32'h2);
        rdc(12'h048, 32'h4);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // falling, both-edge and low-level sense modes
        apb(12'h24c, 1'b1, 32'h3);
        apb(12'h250, 1'b1, 32'h2);
        ext[2] <= 8'h00;
        repeat (5) @(posedge clk);
        rdc(12'h01c, 32'h3);
        apb(12'h24c, 1'b1, 32'h3);
        apb(12'h250, 1'b1, 32'h0);
        ext[2] <= 8'h01;
        repeat (5) @(posedge clk);
        rdc(12'h01c, 32'h1);
        apb(12'h250, 1'b1, 32'h3);
        apb(12'h01c, 1'b1, 32'h2);
        rdc(12'h01c, 32'h3);
        $display("flag test done");
        pstrb <= 4'he;
        apb(12'h000, 1'b1, 32'hff);
        pstrb <= 4'hf;
        rdc(12'h000, 32'h5a);
        rdc(12'hffc, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("refusal test done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({31'h0, |{pin_out, pin_oe, irq}}, 32'h0);
        rdc(12'h040, 32'h0);
        rdc(12'h00c, 32'h0);
        rdc(12'h000, 32'h0);
        $display("reset test done");
        finish_test();
    end
endmodule

bind vpa_top vpa_top_props props_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
